// [include/uif_pkg.sv]
// Shared constants for the UART interrupt identification and FIFO control block.
package uif_pkg;
  // Register byte addresses on the plain register port.
  localparam logic [31:0] ADDR_DATA = 32'hE001_0000; // Rx buffer read, Tx holding write.
  localparam logic [31:0] ADDR_IER = 32'hE001_0004; // Interrupt enable.
  localparam logic [31:0] ADDR_IIR = 32'hE001_0008; // Ident read, FIFO control write.
  localparam logic [31:0] ADDR_LSR = 32'hE001_0014; // Line status, read clears errors.
  localparam logic [31:0] ADDR_MSR = 32'hE001_0018; // Modem status, read clears deltas.
  // Interrupt identification codes, bits 3:0.
  localparam logic [3:0] IIR_NONE = 4'h1;
  localparam logic [3:0] IIR_RLS = 4'h6;
  localparam logic [3:0] IIR_RDA = 4'h4;
  localparam logic [3:0] IIR_CTI = 4'hC;
  localparam logic [3:0] IIR_TX_EMPTY_IRQ = 4'h2;
  localparam logic [3:0] IIR_MODEM = 4'h0;
  // FIFO control field positions and reset value.
  localparam int FCR_EN = 0;
  localparam int FCR_RXRST = 1;
  localparam int FCR_TXRST = 2;
  localparam int FCR_TRIG_LO = 6;
  localparam logic [7:0] FCR_RESET = 8'h00;
  // Interrupt enable field positions and reset value.
  localparam int IER_RDA = 0;
  localparam int IER_TX_EMPTY_IRQ = 1;
  localparam int IER_RLS = 2;
  localparam int IER_MODEM = 3;
  localparam logic [3:0] IER_RESET = 4'h0;
  // Receive trigger levels in characters for codes 00, 01, 10 and 11.
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0E;
  // FIFO geometry.
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int FIFO_CW = 5;
  // Time-out formula terms, in receive sampling clocks.
  localparam logic [9:0] CTI_WL_MUL = 10'h007;
  localparam logic [9:0] CTI_WL_SUB = 10'h002;
  localparam logic [9:0] CTI_SCALE = 10'h008;
  localparam logic [9:0] CTI_ADD = 10'h001;
  localparam logic [3:0] WL_BASE = 4'h5;
  // Sampling clocks per bit, used for the Tx empty start-up delay.
  localparam logic [8:0] SAMPLES_PER_BIT = 9'h010;
endpackage : uif_pkg

// [src/uif_fifo.sv]
// Character FIFO with flush and a single-entry mode for non-FIFO operation.
`timescale 1ns/1ps
module uif_fifo #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_flush,
  input wire logic i_single,
  input wire logic i_push,
  input wire logic [W-1:0] i_wdata,
  input wire logic i_pop,
  output logic [W-1:0] o_rdata,
  output logic [uif_pkg::FIFO_CW-1:0] o_count,
  output logic o_full
);
  // Storage array and pointers.
  logic [W-1:0] mem_q [uif_pkg::FIFO_DEPTH];
  logic [uif_pkg::FIFO_AW-1:0] wp_q;
  logic [uif_pkg::FIFO_AW-1:0] rp_q;
  logic [uif_pkg::FIFO_CW-1:0] cnt_q;
  logic do_push;
  logic do_pop;

  // With FIFOs off the queue acts as a one-character holding register.
  assign o_full = i_single ? (cnt_q != '0) : (int'(cnt_q) == uif_pkg::FIFO_DEPTH);
  assign do_push = i_push && !o_full;
  assign do_pop = i_pop && (cnt_q != '0);
  assign o_rdata = mem_q[rp_q];
  assign o_count = cnt_q;

  // Pointers and fill count; a flush beats any push or pop in the same cycle.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else if (i_flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wp_q <= wp_q + 1'b1;
      if (do_pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + FIFO_CW_ONE(do_push) - FIFO_CW_ONE(do_pop);
    end
  end

  // Data storage needs no reset; contents are only read below the fill count.
  always_ff @(posedge i_clk) begin
    if (do_push && !i_flush) mem_q[wp_q] <= i_wdata;
  end

  // Widens a one-bit strobe to the count width.
  function automatic logic [uif_pkg::FIFO_CW-1:0] FIFO_CW_ONE(input logic b);
    FIFO_CW_ONE = {{(uif_pkg::FIFO_CW-1){1'b0}}, b};
  endfunction : FIFO_CW_ONE
endmodule : uif_fifo

// [src/uif_irq_ctrl.sv]
// UART interrupt prioritisation, identification and FIFO control.
`timescale 1ns/1ps
module uif_irq_ctrl (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [31:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic [2:0] i_rx_err,
  input wire logic i_rclk_tick,
  input wire logic [1:0] i_word_len,
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  input wire logic i_cts,
  input wire logic i_dsr,
  input wire logic i_ri,
  input wire logic i_dcd,
  output logic o_irq
);
  // Control registers.
  logic fen_q; // FIFO enable.
  logic [1:0] trig_q; // Receive trigger select.
  logic [3:0] ier_q; // Interrupt enables.
  logic [7:0] rdata_q; // Registered read data.
  // Access decode.
  logic wr_data, wr_ier, wr_fcr, rd_data, rd_iir, rd_lsr, rd_msr;
  assign wr_data = i_wr && (i_addr == uif_pkg::ADDR_DATA);
  assign wr_ier = i_wr && (i_addr == uif_pkg::ADDR_IER);
  assign wr_fcr = i_wr && (i_addr == uif_pkg::ADDR_IIR);
  assign rd_data = i_rd && (i_addr == uif_pkg::ADDR_DATA);
  assign rd_iir = i_rd && (i_addr == uif_pkg::ADDR_IIR);
  assign rd_lsr = i_rd && (i_addr == uif_pkg::ADDR_LSR);
  assign rd_msr = i_rd && (i_addr == uif_pkg::ADDR_MSR);

  // A write takes bits 7:1 only when it also sets the enable bit.
  logic fcr_gate, fen_chg, rx_flush, tx_flush;
  assign fcr_gate = wr_fcr && i_wdata[uif_pkg::FCR_EN];
  assign fen_chg = wr_fcr && (i_wdata[uif_pkg::FCR_EN] != fen_q);
  assign rx_flush = fen_chg || (fcr_gate && i_wdata[uif_pkg::FCR_RXRST]);
  assign tx_flush = fen_chg || (fcr_gate && i_wdata[uif_pkg::FCR_TXRST]);
  // Reserved bits 5:3 are simply dropped, so stray ones do no harm.

  // FIFO control state; the flush bits are never stored, and a read at this address returns the ident code instead.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fen_q <= uif_pkg::FCR_RESET[uif_pkg::FCR_EN];
      trig_q <= uif_pkg::FCR_RESET[7:6];
    end else if (wr_fcr) begin
      fen_q <= i_wdata[uif_pkg::FCR_EN];
      if (fcr_gate) trig_q <= i_wdata[7:6];
    end
  end

  // Interrupt enable register.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) ier_q <= uif_pkg::IER_RESET;
    else if (wr_ier) ier_q <= i_wdata[3:0];
  end

  // Trigger level in characters.
  logic [4:0] trig_chars;
  always_comb begin
    unique case (trig_q)
      2'b00: trig_chars = uif_pkg::TRIG_L0;
      2'b01: trig_chars = uif_pkg::TRIG_L1;
      2'b10: trig_chars = uif_pkg::TRIG_L2;
      2'b11: trig_chars = uif_pkg::TRIG_L3;
    endcase
  end

  // Receive and transmit queues.
  logic [7:0] rx_head;
  logic [4:0] rx_cnt, tx_cnt;
  logic rx_full, rx_pop, tx_pop;
  assign rx_pop = rd_data && (rx_cnt != '0);
  assign tx_pop = o_tx_valid && i_tx_ready;
  uif_fifo #(.W(8)) u_rx (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_flush(rx_flush), .i_single(!fen_q),
    .i_push(i_rx_valid), .i_wdata(i_rx_data), .i_pop(rx_pop),
    .o_rdata(rx_head), .o_count(rx_cnt), .o_full(rx_full)
  );
  uif_fifo #(.W(8)) u_tx (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_flush(tx_flush), .i_single(!fen_q),
    .i_push(wr_data), .i_wdata(i_wdata), .i_pop(tx_pop),
    .o_rdata(o_tx_data), .o_count(tx_cnt), .o_full()
  );
  // The serialiser sees a character whenever the transmit queue holds one.
  assign o_tx_valid = (tx_cnt != '0);

  // Line error flags: overrun, parity, framing, break. Set wins over the read clear.
  logic [3:0] lerr_q;
  logic [3:0] lerr_set;
  assign lerr_set = {i_rx_err, i_rx_valid && rx_full};
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) lerr_q <= 4'h0;
    else lerr_q <= (rd_lsr ? 4'h0 : lerr_q) | lerr_set;
  end

  // Data available follows the fill level, so draining below trigger drops it.
  logic rx_data_avail_irq;
  assign rx_data_avail_irq = fen_q ? (rx_cnt >= trig_chars) : (rx_cnt != '0);

  // Character time-out limit in sampling clocks.
  logic [9:0] cti_base, cti_def, cti_lim;
  always_comb begin
    cti_base = (10'(uif_pkg::WL_BASE + {2'b00, i_word_len}) * uif_pkg::CTI_WL_MUL
      - uif_pkg::CTI_WL_SUB) * uif_pkg::CTI_SCALE;
    cti_def = (trig_chars > rx_cnt) ? 10'(trig_chars - rx_cnt) : 10'h000;
    cti_lim = cti_base + cti_def * uif_pkg::CTI_SCALE + uif_pkg::CTI_ADD;
  end

  // Idle timer: any queue activity or an empty queue restarts it.
  logic [9:0] cti_cnt_q;
  logic cti_q, rx_act;
  assign rx_act = i_rx_valid || rx_pop || rx_flush;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) cti_cnt_q <= 10'h000;
    else if (rx_act || rx_cnt == '0) cti_cnt_q <= 10'h000;
    else if (i_rclk_tick && cti_cnt_q != cti_lim) cti_cnt_q <= cti_cnt_q + 10'h001;
  end

  // Time-out flag; a buffer read is activity, so it clears the flag.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) cti_q <= 1'b0;
    else if (rx_act) cti_q <= 1'b0;
    else if (rx_cnt != '0 && cti_cnt_q == cti_lim) cti_q <= 1'b1;
  end

  // Transmitter empty tracking.
  logic tx_empty, empty_q, became_empty, two_seen_q, dly_act_q, tx_empty_irq_q, tx_empty_irq_set;
  logic [8:0] dly_cnt_q, dly_lim;
  assign tx_empty = (tx_cnt == '0);
  assign became_empty = tx_empty && !empty_q;
  // Delay is the start bit plus data bits, leaving the stop bit out.
  assign dly_lim = 9'(4'h1 + uif_pkg::WL_BASE + {2'b00, i_word_len}) * uif_pkg::SAMPLES_PER_BIT;
  assign tx_empty_irq_set = (became_empty && two_seen_q)
    || (dly_act_q && tx_empty && i_rclk_tick && dly_cnt_q == dly_lim - 9'h001);

  // Previous empty level; reset as empty, so no event is raised before any write.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) empty_q <= 1'b1;
    else empty_q <= tx_empty;
  end

  // Remembers that the queue held two characters since the last empty event.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) two_seen_q <= 1'b0;
    else if (tx_cnt >= 5'h02) two_seen_q <= 1'b1;
    else if (tx_empty_irq_set) two_seen_q <= 1'b0;
  end

  // Start-up delay timer; a refill cancels it so a late event is never raised.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dly_act_q <= 1'b0;
      dly_cnt_q <= 9'h000;
    end else if (became_empty && !two_seen_q) begin
      dly_act_q <= 1'b1;
      dly_cnt_q <= 9'h000;
    end else if (!tx_empty || tx_empty_irq_set) begin
      dly_act_q <= 1'b0;
    end else if (dly_act_q && i_rclk_tick) begin
      dly_cnt_q <= dly_cnt_q + 9'h001;
    end
  end

  // Modem input history; the first cycle after reset only primes it.
  logic primed_q;
  logic [3:0] mprev_q, mdelta_q, mset;
  assign mset = primed_q ? {i_dcd ^ mprev_q[3], i_ri && !mprev_q[2],
    i_dsr ^ mprev_q[1], i_cts ^ mprev_q[0]} : 4'h0;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      primed_q <= 1'b0;
      mprev_q <= 4'h0;
    end else begin
      primed_q <= 1'b1;
      mprev_q <= {i_dcd, i_ri, i_dsr, i_cts};
    end
  end

  // Modem deltas; a change in the reading cycle survives the clear.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) mdelta_q <= 4'h0;
    else mdelta_q <= (rd_msr ? 4'h0 : mdelta_q) | mset;
  end

  // Enabled sources and priority encoding.
  logic rls_on, rda_on, cti_on, tx_empty_irq_on, mdm_on;
  logic [3:0] iir_id;
  assign rls_on = ier_q[uif_pkg::IER_RLS] && (lerr_q != 4'h0);
  assign rda_on = ier_q[uif_pkg::IER_RDA] && rx_data_avail_irq;
  assign cti_on = ier_q[uif_pkg::IER_RDA] && cti_q;
  assign tx_empty_irq_on = ier_q[uif_pkg::IER_TX_EMPTY_IRQ] && tx_empty_irq_q;
  assign mdm_on = ier_q[uif_pkg::IER_MODEM] && (mdelta_q != 4'h0);
  always_comb begin
    if (rls_on) iir_id = uif_pkg::IIR_RLS;
    else if (rda_on) iir_id = uif_pkg::IIR_RDA;
    else if (cti_on) iir_id = uif_pkg::IIR_CTI;
    else if (tx_empty_irq_on) iir_id = uif_pkg::IIR_TX_EMPTY_IRQ;
    else if (mdm_on) iir_id = uif_pkg::IIR_MODEM;
    else iir_id = uif_pkg::IIR_NONE;
  end
  assign o_irq = !iir_id[0];

  // Tx empty flag; a new event in the clearing cycle wins.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) tx_empty_irq_q <= 1'b0;
    else if (tx_empty_irq_set) tx_empty_irq_q <= 1'b1;
    else if (wr_data || (rd_iir && iir_id == uif_pkg::IIR_TX_EMPTY_IRQ)) tx_empty_irq_q <= 1'b0;
  end

  // Read data, valid the cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) rdata_q <= 8'h00;
    else if (rd_data) rdata_q <= (rx_cnt != '0) ? rx_head : 8'h00;
    else if (i_rd && i_addr == uif_pkg::ADDR_IER) rdata_q <= {4'h0, ier_q};
    else if (rd_iir) rdata_q <= {fen_q, fen_q, 2'b00, iir_id};
    else if (rd_lsr) rdata_q <= {1'b0, tx_empty, tx_empty, lerr_q, rx_cnt != '0};
    else if (rd_msr) rdata_q <= {i_dcd, i_ri, i_dsr, i_cts, mdelta_q};
    else if (i_rd) rdata_q <= 8'h00;
  end
  assign o_rdata = rdata_q;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_rls_top;
    (i_rx_err != 3'b000) && ier_q[uif_pkg::IER_RLS] && !rd_lsr |=> iir_id == 4'h6;
  endproperty
  a_rls_top: assert property (p_rls_top) else $error("line error not top");
  property p_rda;
    rda_on && !rls_on |-> iir_id == 4'h4;
  endproperty
  a_rda: assert property (p_rda) else $error("data available code wrong");
  property p_cti_code;
    cti_on && !rda_on && !rls_on |-> iir_id == 4'hC;
  endproperty
  a_cti_code: assert property (p_cti_code) else $error("time-out code wrong");
  property p_cti_cause;
    $rose(cti_q) |-> $past(rx_cnt) != 5'h00 && $past(cti_cnt_q) == $past(cti_lim);
  endproperty
  a_cti_cause: assert property (p_cti_cause) else $error("time-out without cause");
  property p_tx_empty_irq_now;
    became_empty && two_seen_q |=> tx_empty_irq_q;
  endproperty
  a_tx_empty_irq_now: assert property (p_tx_empty_irq_now) else $error("tx empty not immediate");
  property p_tx_empty_irq_wait;
    became_empty && !two_seen_q |=> !tx_empty_irq_q [*2];
  endproperty
  a_tx_empty_irq_wait: assert property (p_tx_empty_irq_wait) else $error("tx empty not delayed");
  property p_tx_empty_irq_clr;
    wr_data && !tx_empty_irq_set |=> !tx_empty_irq_q;
  endproperty
  a_tx_empty_irq_clr: assert property (p_tx_empty_irq_clr) else $error("tx write did not clear");
  property p_ri_rise;
    primed_q && i_ri && !mprev_q[2] |=> mdelta_q[2];
  endproperty
  a_ri_rise: assert property (p_ri_rise) else $error("ring rise missed");
  property p_flush;
    fen_chg |=> rx_cnt == 5'h00 && tx_cnt == 5'h00;
  endproperty
  a_flush: assert property (p_flush) else $error("enable change did not flush");
  property p_idle;
    o_irq == (rls_on || rda_on || cti_on || tx_empty_irq_on || mdm_on);
  endproperty
  a_idle: assert property (p_idle) else $error("pending bit wrong");
  property p_iir_read;
    rd_iir |=> o_rdata[7:6] == {2{$past(fen_q)}} && o_rdata[3:0] == $past(iir_id);
  endproperty
  a_iir_read: assert property (p_iir_read) else $error("ident read wrong");

  c_cti: cover property (cti_on && !rda_on);
  c_tx_empty_irq_dly: cover property (dly_act_q ##1 tx_empty_irq_q);
  c_modem: cover property (mdm_on ##1 rd_msr);
  c_rls: cover property (rls_on && rda_on);
endmodule : uif_irq_ctrl

// [test/uif_peer.sv]
// Serial line peer and modem line model on the far side of the UART control block.
`timescale 1ns/1ps
module uif_peer (
  input wire logic i_clk,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic [2:0] o_rx_err,
  output logic o_rclk_tick,
  output logic [3:0] o_modem
);
  // Holds off the serialiser so that the transmit queue can build up.
  logic stall;
  // Runs the sampling tick; it stands still otherwise so timers freeze.
  logic tick_en;
  // Characters taken from the transmit queue, oldest first.
  logic [7:0] txq [$];

  // Idle levels; the data lines start on a pattern that is not a real character.
  initial begin
    stall = 1'b0;
    tick_en = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_data = 8'hA5;
    o_rx_err = 3'h0;
    o_rclk_tick = 1'b0;
    o_modem = 4'h0;
  end

  // The serialiser is ready whenever it is not stalled.
  assign o_tx_ready = !stall;

  // Sampling tick, one per cycle while enabled, to keep long timers short.
  always @(posedge i_clk) begin
    o_rclk_tick <= tick_en;
  end

  // Every accepted transfer lands in the queue for the bench to compare.
  always @(posedge i_clk) begin
    if (i_tx_valid && o_tx_ready) begin
      txq.push_back(i_tx_data);
    end
  end

  // One received character with its error flags; afterwards the data lines
  // carry the inverse so a stale value can never pass for a fresh one.
  task automatic rx_char(input logic [7:0] d, input logic [2:0] e);
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_data <= d;
    o_rx_err <= e;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~d;
    o_rx_err <= 3'h0;
  endtask : rx_char

  // Modem levels as {dcd, ri, dsr, cts}, changed just after an edge.
  task automatic set_modem(input logic [3:0] v);
    @(posedge i_clk);
    o_modem <= v;
  endtask : set_modem
endmodule : uif_peer

// [test/tb_top.sv]
// Self-checking bench for the UART interrupt identification and FIFO control block.
`timescale 1ns/1ps
module tb_top;
  logic i_clk, i_nrst, i_wr, i_rd, rx_valid, tick, tx_valid, tx_ready, irq;
  logic [31:0] i_addr;
  logic [7:0] i_wdata, rdata, rx_data, tx_data, rv;
  logic [2:0] rx_err;
  logic [3:0] modem, mv;
  // Word length select, changed mid-run so the length-dependent timers are exercised.
  logic [1:0] wl;
  int fail_count, samples_checked, cyc, seed;
  // Reference state: FIFO enable and the expected receive queue.
  logic fen;
  logic [7:0] rxq [$];

  uif_irq_ctrl uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .i_rx_err(rx_err), .i_rclk_tick(tick), .i_word_len(wl), .o_tx_valid(tx_valid),
    .o_tx_data(tx_data), .i_tx_ready(tx_ready), .i_cts(modem[0]), .i_dsr(modem[1]),
    .i_ri(modem[2]), .i_dcd(modem[3]), .o_irq(irq));
  uif_peer u_peer (.i_clk(i_clk), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
    .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_err(rx_err),
    .o_rclk_tick(tick), .o_modem(modem));

  // 100 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // Hang guard: the whole sequence needs well under this many cycles.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      $display("unexpected at %0t: cycle limit reached", $time);
      fail_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  // One-cycle write strobe.
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // One-cycle read strobe; the data stand only in the following cycle.
  task automatic rd_chk(input logic [31:0] a, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(rdata & mask, exp & mask);
  endtask : rd_chk

  task automatic iir(input logic [3:0] code);
    rd_chk(uif_pkg::ADDR_IIR, {fen, fen, 2'h0, code}, 8'hCF);
  endtask : iir

  // Control write; the reference flushes on an enable change or on bit 1 when enabled.
  task automatic fcr(input logic [7:0] d);
    wr(uif_pkg::ADDR_IIR, d);
    if (d[0] !== fen) rxq.delete();
    if (d[0] && d[1]) rxq.delete();
    fen = d[0];
  endtask : fcr

  // Receive buffer read against the reference queue; an empty buffer reads 0.
  task automatic pop_chk();
    rv = (rxq.size() > 0) ? rxq.pop_front() : 8'h00;
    rd_chk(uif_pkg::ADDR_DATA, rv, 8'hFF);
  endtask : pop_chk

  task automatic send(input logic [2:0] e);
    logic [7:0] d;
    d = 8'($random(seed));
    u_peer.rx_char(d, e);
    rxq.push_back(d);
  endtask : send

  initial begin
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 32'h0000_0000;
    i_wdata = 8'h00;
    fen = 1'b0;
    wl = 2'h3;
    cyc = 0;
    fail_count = 0;
    samples_checked = 0;
    seed = 32'h5C9E;
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
    iir(uif_pkg::IIR_NONE);
    rd_chk(32'hE001_0020, 8'h00, 8'hFF);
    fcr(8'h41);
    iir(uif_pkg::IIR_NONE);
    wr(uif_pkg::ADDR_IER, 8'h0F);
    repeat (3) send(3'h0);
    iir(uif_pkg::IIR_NONE);
    send(3'h0);
    iir(uif_pkg::IIR_RDA);
    pop_chk();
    iir(uif_pkg::IIR_NONE);
    // Three held, trigger 4, 8-bit words: 441 ticks to the time-out.
    u_peer.tick_en <= 1'b1;
    repeat (430) @(posedge i_clk);
    iir(uif_pkg::IIR_NONE);
    repeat (20) @(posedge i_clk);
    iir(uif_pkg::IIR_CTI);
    pop_chk();
    iir(uif_pkg::IIR_NONE);
    u_peer.tick_en <= 1'b0;
    // A parity error on the fourth character outranks the data available source.
    send(3'h0);
    send(3'h1);
    iir(uif_pkg::IIR_RLS);
    rd_chk(uif_pkg::ADDR_LSR, 8'h05, 8'h1F);
    iir(uif_pkg::IIR_RDA);
    fcr(8'h43);
    iir(uif_pkg::IIR_NONE);
    pop_chk();
    // The top trigger level needs fourteen characters before data available shows.
    fcr(8'hC1);
    repeat (13) send(3'h0);
    iir(uif_pkg::IIR_NONE);
    send(3'h0);
    iir(uif_pkg::IIR_RDA);
    // One enable bit gates both receive sources.
    fcr(8'h01);
    wr(uif_pkg::ADDR_IER, 8'h0E);
    send(3'h0);
    iir(uif_pkg::IIR_NONE);
    wr(uif_pkg::ADDR_IER, 8'h0F);
    iir(uif_pkg::IIR_RDA);
    fcr(8'h00);
    iir(uif_pkg::IIR_NONE);
    pop_chk();
    // With the enable bit low the flush request in the same write is ignored.
    send(3'h0);
    fcr(8'hC2);
    pop_chk();
    fcr(8'h01);
    // Each modem line in turn; RI counts only on its rising edge.
    mv = 4'h0;
    for (int i = 0; i < 4; i++) begin
      mv[i] = 1'b1;
      u_peer.set_modem(mv);
      iir(uif_pkg::IIR_MODEM);
      rd_chk(uif_pkg::ADDR_MSR, {mv, 4'(1 << i)}, 8'hFF);
      iir(uif_pkg::IIR_NONE);
    end
    mv[2] = 1'b0;
    u_peer.set_modem(mv);
    iir(uif_pkg::IIR_NONE);
    // Two characters held at once, then drained: the empty source is immediate.
    u_peer.stall <= 1'b1;
    wr(uif_pkg::ADDR_DATA, 8'h3C);
    wr(uif_pkg::ADDR_DATA, 8'hC3);
    #1;
    chk({7'h00, tx_valid}, 8'h01);
    u_peer.stall <= 1'b0;
    repeat (4) @(posedge i_clk);
    iir(uif_pkg::IIR_TX_EMPTY_IRQ);
    iir(uif_pkg::IIR_NONE);
    // A lone character waits 144 ticks after the queue empties.
    u_peer.tick_en <= 1'b1;
    wr(uif_pkg::ADDR_DATA, 8'h5A);
    repeat (100) @(posedge i_clk);
    iir(uif_pkg::IIR_NONE);
    repeat (50) @(posedge i_clk);
    iir(uif_pkg::IIR_TX_EMPTY_IRQ);
    u_peer.stall <= 1'b1;
    wr(uif_pkg::ADDR_DATA, 8'h77);
    iir(uif_pkg::IIR_NONE);
    wl <= 2'h0;
    fcr(8'h05);
    #1;
    chk({7'h00, tx_valid}, 8'h00);
    chk(8'(u_peer.txq.size()), 8'h03);
    foreach (u_peer.txq[k]) begin
      chk(u_peer.txq[k], (k == 0) ? 8'h3C : (k == 1) ? 8'hC3 : 8'h5A);
    end
    // The flush empties a lone character again; 5-bit words shorten the wait to 96 ticks.
    repeat (90) @(posedge i_clk);
    #1;
    chk({7'h00, irq}, 8'h00);
    repeat (10) @(posedge i_clk);
    #1;
    chk({7'h00, irq}, 8'h01);
    // A holding write, with no ident read before it, is what clears this pending source.
    wr(uif_pkg::ADDR_DATA, 8'h11);
    #1;
    chk({7'h00, irq}, 8'h00);
    complete_run();
  end
endmodule : tb_top
